/* pkg/tsq_pkg.sv */
// Constants, field layouts and state types of the trace sequencer.
// Assumes one sample per enabled CLK edge and an AXI4-Lite register port.
package tsq_pkg;
    // Level set and counter sizes
    localparam int LVL_W   = 4;
    localparam int NUM_LVL = 16;
    localparam int DLY_W   = 16;
    localparam int CNT_W   = 16;
    localparam int AXI_AW  = 12;
    localparam int AXI_DW  = 32;
    localparam int STRB_W  = 4;

    localparam logic [LVL_W-1:0] LVL_FIRST = 4'h0;
    localparam logic [LVL_W-1:0] LVL_LAST  = 4'hF;
    localparam logic [LVL_W-1:0] LVL_ONE   = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;
    localparam logic [DLY_W-1:0] DLY_RST   = 16'h0203;

    // Register map
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [AXI_AW-1:0] ADDR_STAT = 12'h004;
    localparam logic [AXI_AW-1:0] AREA_LO   = 12'h100;
    localparam logic [AXI_AW-1:0] AREA_HI   = 12'h180;
    localparam int IDX_LSB      = 3;
    localparam int SEL_DLY_BIT  = 2;
    localparam int CTRL_ARM_BIT = 0;
    localparam int STAT_STOP    = 4;
    localparam int STAT_CNT_LSB = 16;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Match input bit positions, one per condition term
    localparam int M_TRACE = 0;
    localparam int M_ADV   = 1;
    localparam int M_JUMP  = 2;
    localparam int M_STOP  = 3;
    localparam int NUM_TERM = 4;

    typedef enum logic [1:0] {TERM_NEVER, TERM_ALWAYS, TERM_MATCH} tsq_mode_e;
    typedef enum logic [1:0] {QUAL_NONE, QUAL_GT, QUAL_LE, QUAL_EQ} tsq_qual_e;

    typedef struct packed {
        tsq_qual_e qual;
        tsq_mode_e mode;
    } tsq_term_s;

    typedef struct packed {
        logic             count_pat;
        logic [LVL_W-1:0] jump_to;
        tsq_term_s        stop;
        tsq_term_s        jump;
        tsq_term_s        adv;
        tsq_term_s        trace;
    } tsq_lvl_s;

    localparam int CFG_W = $bits(tsq_lvl_s);
    localparam tsq_lvl_s CFG_RST = '0;

    typedef struct packed {
        tsq_lvl_s [NUM_LVL-1:0]            cfg;
        logic [NUM_LVL-1:0][DLY_W-1:0]     dly;
        logic [LVL_W-1:0]                  level;
        logic [CNT_W-1:0]                  count;
        logic                              stopped;
        logic                              store;
        logic                              awready;
        logic                              wready;
        logic                              aw_got;
        logic                              w_got;
        logic [AXI_AW-1:0]                 awaddr;
        logic [AXI_DW-1:0]                 wdata;
        logic [STRB_W-1:0]                 wstrb;
        logic                              bvalid;
        logic [1:0]                        bresp;
        logic                              arready;
        logic                              rvalid;
        logic [AXI_DW-1:0]                 rdata;
        logic [1:0]                        rresp;
    } tsq_state_s;
endpackage

/* hw/tsq_term.sv */
// One condition term of a sequencer level: mode, count qualifier, result.
// Assumes the caller gives the sample count including the present sample.
`timescale 1ns/1ps
module tsq_term
    import tsq_pkg::*;
(
    input  tsq_pkg::tsq_term_s        term,
    input  wire logic                 match,
    input  wire logic [tsq_pkg::CNT_W-1:0] cnt,
    input  wire logic [tsq_pkg::DLY_W-1:0] dly,
    output logic                      hit
);
    logic base;
    logic qual_ok;

    // Base condition, then the count comparison against the delay
    always_comb
    begin
        case (term.mode)
            TERM_ALWAYS: base = 1'b1;
            TERM_MATCH:  base = match;
            default:     base = 1'b0;
        endcase
        case (term.qual)
            QUAL_GT: qual_ok = cnt > dly;
            QUAL_LE: qual_ok = cnt <= dly;
            QUAL_EQ: qual_ok = cnt == dly;
            default: qual_ok = 1'b1;
        endcase
        hit = base && qual_ok;
    end
endmodule

/* hw/tsq_seq.sv */
// Multi-level trace sequencer with AXI4-Lite register access.
// Assumes MATCH comes from external pattern comparators, one bit per term,
// valid for the sample taken at each CLK edge with CE high.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tsq_seq
    import tsq_pkg::*;
(
    input  wire logic                       CLK,
    input  wire logic                       NRST,
    input  wire logic                       CE,
    input  wire logic [NUM_TERM-1:0]        MATCH,
    output logic                            STORE,
    output logic [tsq_pkg::LVL_W-1:0]       LEVEL,
    output logic                            STOPPED,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    input  wire logic [tsq_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    input  wire logic [tsq_pkg::AXI_DW-1:0] S_AXI_WDATA,
    input  wire logic [tsq_pkg::STRB_W-1:0] S_AXI_WSTRB,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    output logic [1:0]                      S_AXI_BRESP,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    input  wire logic [tsq_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    output logic [tsq_pkg::AXI_DW-1:0]      S_AXI_RDATA,
    output logic [1:0]                      S_AXI_RRESP
);
    import tsq_pkg::*;

    tsq_state_s         s;
    tsq_state_s         next_s;
    tsq_lvl_s           cur;
    logic [DLY_W-1:0]   cur_dly;
    logic [CNT_W-1:0]   cnt_eff;
    logic [NUM_TERM-1:0] hit;
    logic               arm_fire;
    logic               live;

    // Byte-lane merge for register writes
    function automatic logic [AXI_DW-1:0] wmerge(input logic [AXI_DW-1:0] old,
                                                  input logic [AXI_DW-1:0] nw,
                                                  input logic [STRB_W-1:0] st);
        logic [AXI_DW-1:0] r;
        r = old;
        for (int i = 0; i < STRB_W; i++)
            if (st[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // Current level's settings and its sample count including this sample
    assign cur     = s.cfg[s.level];
    assign cur_dly = s.dly[s.level];
    assign cnt_eff = ((cur.count_pat ? MATCH[M_ADV] : 1'b1) && s.count != CNT_MAX)
                   ? s.count + CNT_ONE : s.count;

    // Four term evaluators on the current level
    tsq_term u_trace (.term(cur.trace), .match(MATCH[M_TRACE]), .cnt(cnt_eff),
                      .dly(cur_dly), .hit(hit[M_TRACE]));
    tsq_term u_adv   (.term(cur.adv),   .match(MATCH[M_ADV]),   .cnt(cnt_eff),
                      .dly(cur_dly), .hit(hit[M_ADV]));
    tsq_term u_jump  (.term(cur.jump),  .match(MATCH[M_JUMP]),  .cnt(cnt_eff),
                      .dly(cur_dly), .hit(hit[M_JUMP]));
    tsq_term u_stop  (.term(cur.stop),  .match(MATCH[M_STOP]),  .cnt(cnt_eff),
                      .dly(cur_dly), .hit(hit[M_STOP]));

    // Next state: register port first, then the sequencer
    always_comb
    begin
        logic [AXI_DW-1:0] wtmp;
        logic [AXI_DW-1:0] rd;
        logic [1:0]        resp;
        logic [LVL_W-1:0]  idx;
        logic              go_w;
        wtmp = '0;
        rd = '0;
        resp = RESP_OKAY;
        idx = '0;
        go_w = 1'b0;
        next_s = s;
        arm_fire = 1'b0;

        // Write address and data are taken in either order
        if (s.awready && S_AXI_AWVALID)
        begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = S_AXI_AWADDR;
        end
        if (s.wready && S_AXI_WVALID)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = S_AXI_WDATA;
            next_s.wstrb = S_AXI_WSTRB;
        end
        if (s.bvalid && S_AXI_BREADY)
            next_s.bvalid = 1'b0;
        go_w = s.aw_got && s.w_got && !s.bvalid;

        // Write decode
        if (go_w)
        begin
            idx = s.awaddr[IDX_LSB +: LVL_W];
            if (s.awaddr == ADDR_CTRL)
            begin
                arm_fire = s.wstrb[0] && s.wdata[CTRL_ARM_BIT];
            end
            else if (s.awaddr == ADDR_STAT)
            begin
                resp = RESP_OKAY;
            end
            else if (s.awaddr >= AREA_LO && s.awaddr < AREA_HI)
            begin
                if (s.awaddr[SEL_DLY_BIT])
                begin
                    wtmp = wmerge({{(AXI_DW-DLY_W){1'b0}}, s.dly[idx]}, s.wdata, s.wstrb);
                    next_s.dly[idx] = wtmp[DLY_W-1:0];
                end
                else
                begin
                    wtmp = wmerge({{(AXI_DW-CFG_W){1'b0}}, s.cfg[idx]}, s.wdata, s.wstrb);
                    next_s.cfg[idx] = tsq_lvl_s'(wtmp[CFG_W-1:0]);
                end
            end
            else
            begin
                resp = RESP_SLVERR;
            end
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = resp;
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;

        // Read channel: one outstanding read
        if (s.rvalid && S_AXI_RREADY)
            next_s.rvalid = 1'b0;
        if (s.arready && S_AXI_ARVALID)
        begin
            resp = RESP_OKAY;                                // Not the write's code
            idx = S_AXI_ARADDR[IDX_LSB +: LVL_W];
            if (S_AXI_ARADDR == ADDR_CTRL)
            begin
                rd = '0;
            end
            else if (S_AXI_ARADDR == ADDR_STAT)
            begin
                rd[LVL_W-1:0] = s.level;
                rd[STAT_STOP] = s.stopped;
                rd[STAT_CNT_LSB +: CNT_W] = s.count;
            end
            else if (S_AXI_ARADDR >= AREA_LO && S_AXI_ARADDR < AREA_HI)
            begin
                if (S_AXI_ARADDR[SEL_DLY_BIT])
                    rd[DLY_W-1:0] = s.dly[idx];
                else
                    rd[CFG_W-1:0] = s.cfg[idx];
            end
            else
            begin
                resp = RESP_SLVERR;
            end
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd;
            next_s.rresp  = resp;
        end
        next_s.arready = !next_s.rvalid;

        // Sequencer, one step per sample
        next_s.store = 1'b0;
        if (arm_fire)
        begin
            next_s.level   = LVL_FIRST;
            next_s.count   = CNT_ZERO;
            next_s.stopped = 1'b0;
        end
        else if (!s.stopped)
        begin
            next_s.store = hit[M_TRACE];
            next_s.count = cnt_eff;
            if (hit[M_STOP])
            begin
                next_s.stopped = 1'b1;
            end
            else if (hit[M_JUMP])
            begin
                next_s.level = cur.jump_to;
                next_s.count = CNT_ZERO;
            end
            else if (hit[M_ADV] && s.level != LVL_LAST)
            begin
                next_s.level = s.level + LVL_ONE;
                next_s.count = CNT_ZERO;
            end
        end
    end

    // State register, frozen while CE is low
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            s         <= '0;
            s.cfg     <= {NUM_LVL{CFG_RST}};
            s.dly     <= {NUM_LVL{DLY_RST}};
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end
        else if (CE)
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign STORE         = s.store;
    assign LEVEL         = s.level;
    assign STOPPED       = s.stopped;
    assign S_AXI_AWREADY = s.awready;
    assign S_AXI_WREADY  = s.wready;
    assign S_AXI_BVALID  = s.bvalid;
    assign S_AXI_BRESP   = s.bresp;
    assign S_AXI_ARREADY = s.arready;
    assign S_AXI_RVALID  = s.rvalid;
    assign S_AXI_RDATA   = s.rdata;
    assign S_AXI_RRESP   = s.rresp;

    // Checks on the sequencer
    assign live = CE && !arm_fire && !s.stopped;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_stop_latch: assert property (live && hit[M_STOP] |=> STOPPED && LEVEL == $past(LEVEL))
        else $error("stop term did not end recording");
    a_stop_hold: assert property (STOPPED && CE && !arm_fire |=> STOPPED && !STORE)
        else $error("recording resumed without arm");
    a_store_trace: assert property (live |=> STORE == $past(hit[M_TRACE]))
        else $error("store does not follow trace term");
    a_jump_target: assert property (live && !hit[M_STOP] && hit[M_JUMP]
        |=> LEVEL == $past(cur.jump_to) && s.count == CNT_ZERO)
        else $error("jump did not reach target with cleared count");
    a_adv_next: assert property (live && hit[M_ADV] && !hit[M_JUMP] && !hit[M_STOP]
        && LEVEL != LVL_LAST |=> LEVEL == $past(LEVEL) + LVL_ONE && s.count == CNT_ZERO)
        else $error("advance did not reach next level");
    a_jump_over_adv: assert property (live && hit[M_JUMP] && hit[M_ADV] && !hit[M_STOP]
        |=> LEVEL == $past(cur.jump_to))
        else $error("advance won over jump");
    a_count_clocks: assert property (live && !cur.count_pat && hit[M_STOP:M_ADV] == '0
        && s.count != CNT_MAX |=> s.count == $past(s.count) + CNT_ONE)
        else $error("clock count did not step");
    a_arm_start: assert property (CE && arm_fire
        |=> LEVEL == LVL_FIRST && !STOPPED && s.count == CNT_ZERO && !STORE)
        else $error("arm did not restart at level 0");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");

    c_stop: cover property (live && hit[M_STOP]);
    c_jump: cover property (live && hit[M_JUMP] && !hit[M_STOP]);
    c_last_level: cover property (LEVEL == LVL_LAST);
    c_store_eq: cover property (live && hit[M_TRACE] && cur.trace.qual == QUAL_EQ);
endmodule

/* dv/tsq_probe.sv */
// Model of the probed bus seen through the pattern comparators.
// Assumes one sample per CLK edge with CE high, as the sequencer does.
`timescale 1ns/1ps
module tsq_probe
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [3:0] pat,
    input  wire logic [3:0] per,
    output logic      [3:0] match
);
    logic [3:0] cnt;

    // Raise the pattern bits once every per samples, zero in between
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt   <= 4'h0;
            match <= 4'h0;
        end
        else if (ce)
        begin
            if (cnt + 4'h1 >= per)
            begin
                cnt   <= 4'h0;
                match <= pat;
            end
            else
            begin
                cnt   <= cnt + 4'h1;
                match <= 4'h0;
            end
        end
    end
endmodule

/* dv/tb.sv */
// Self-checking bench: registers over AXI4-Lite, level programs, verdict.
// Assumes the sequencer runs after reset and the probe model feeds MATCH.
`timescale 1ns/1ps
module tb;
    import tsq_pkg::*;
    localparam logic [AXI_AW-1:0] ADDR_LVL0 = 12'h100;
    logic                clk;
    logic                nrst;
    logic                ce;
    logic [NUM_TERM-1:0] match;
    logic                store;
    logic                stopped;
    logic [LVL_W-1:0]    level;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready;
    logic [AXI_AW-1:0]   awaddr, araddr;
    logic [AXI_DW-1:0]   wdata, rdata;
    logic [STRB_W-1:0]   wstrb;
    logic [1:0]          bresp, rresp;
    logic [3:0]          pat, per;
    logic [31:0]         d;
    int                  err_count, n_checks, store_cnt;

    tsq_seq dut (.CLK(clk), .NRST(nrst), .CE(ce), .MATCH(match), .STORE(store),
        .LEVEL(level), .STOPPED(stopped), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp));
    tsq_probe probe (.clk(clk), .nrst(nrst), .ce(ce), .pat(pat), .per(per), .match(match));

    // Clock at 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Count samples written to memory
    always @(posedge clk)
    begin
        if (!nrst)
            store_cnt <= 0;
        else if (store === 1'b1)
            store_cnt <= store_cnt + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One write; address and data offered together, each dropped when taken
    task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= v;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        if (n >= 100)
            err_count++;
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        @(posedge clk);
    endtask

    // One read; returns data and checks the response code
    task automatic axr(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        if (n >= 100)
            err_count++;
        v = rdata;
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // Program one level: condition word and delay
    task automatic lvl(input int n, input logic [31:0] c, input logic [31:0] dl);
        axw(12'(32'h100 + 8 * n), c, RESP_OKAY);
        axw(12'(32'h104 + 8 * n), dl, RESP_OKAY);
    endtask

    // Arm; level 0 jumps at once to tgt; wait for the stop and compare.
    // Stores are counted from the arm on, so samples taken before it do not count.
    task automatic run(input logic [3:0] tgt, input logic [3:0] p, input logic [3:0] pr,
                       input int es, input logic [3:0] el, input logic last);
        int s0;
        int n;
        pat <= p;
        per <= pr;
        axw(ADDR_LVL0, 32'h100 | (32'(tgt) << 16), RESP_OKAY);
        axw(ADDR_CTRL, 32'h1, RESP_OKAY);
        s0 = store_cnt;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (stopped !== 1'b1 && n < 3000);
        if (n >= 3000)
            err_count++;
        chk(32'(store), 32'(last));
        chk(32'(level), 32'(el));
        @(posedge clk);
        chk(32'(store_cnt - s0), 32'(es));
        axr(ADDR_STAT, d, RESP_OKAY);
        chk(32'(d[4:0]), {27'h0, 1'b1, el});
        $display("test from level %h done", tgt);
    endtask

    // Watchdog
    initial
    begin
        #300us;
        err_count++;
        complete_run();
    end

    initial
    begin
        nrst = 1'b0; ce = 1'b1; pat = 4'h0; per = 4'h1;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'hF;
        err_count = 0; n_checks = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset state and register access
        axr(ADDR_STAT, d, RESP_OKAY);
        chk(32'(d[4:0]), 32'h0);
        axr(12'h128, d, RESP_OKAY);
        chk(d, 32'h0);
        axr(12'h12C, d, RESP_OKAY);
        chk(d, 32'h00000203);
        axw(12'h12C, 32'h000064FF, RESP_OKAY);
        axr(12'h12C, d, RESP_OKAY);
        chk(d, 32'h000064FF);
        axw(12'h12C, 32'hFFFFFFFF, RESP_OKAY);
        axr(12'h12C, d, RESP_OKAY);
        chk(d, 32'h0000FFFF);
        axr(12'h200, d, RESP_SLVERR);
        chk(d, 32'h0);
        axw(12'h200, 32'h1, RESP_SLVERR);
        axw(ADDR_STAT, 32'h1F, RESP_OKAY);
        $display("register test done");
        // Level programs
        lvl(1, 32'hD1, 21);
        lvl(2, 32'h1000, 515);
        run(4'h1, 4'h0, 4'h1, 21, 4'h2, 1'b0);
        lvl(3, 32'hD001, 55);
        run(4'h3, 4'h0, 4'h1, 55, 4'h3, 1'b1);
        lvl(4, 32'h1000EE, 255);
        lvl(5, 32'h1000, 515);
        run(4'h4, 4'h3, 4'h3, 1, 4'h5, 1'b0);
        lvl(6, 32'h1000E2, 32);
        lvl(7, 32'h1000, 515);
        run(4'h6, 4'h3, 4'h3, 32, 4'h7, 1'b0);
        lvl(8, 32'h92221, 515);
        lvl(9, 32'h1000, 515);
        run(4'h8, 4'hF, 4'h1, 1, 4'h8, 1'b1);
        lvl(10, 32'hC0220, 515);
        lvl(11, 32'h1000, 515);
        lvl(12, 32'h1000, 515);
        run(4'hA, 4'h6, 4'h1, 0, 4'hC, 1'b0);
        run(4'hA, 4'h2, 4'h1, 0, 4'hB, 1'b0);
        lvl(13, 32'h59, 4);
        lvl(14, 32'h1000, 515);
        run(4'hD, 4'h0, 4'h1, 4, 4'hE, 1'b0);
        lvl(15, 32'hD010, 3);
        run(4'hF, 4'h0, 4'h1, 0, 4'hF, 1'b0);
        complete_run();
    end
endmodule
